// ==== common/dea_pkg.sv ====
// Overview of operation
// R1 - Array holds 64 bytes at 00H-3FH
// R2 - One byte per access via three registers
// R3 - Control sits at 40H, sector 1 only
// R4 - Address register six bits, top reads zero
// R5 - Bit 3 store enable, bits 7-4 zero
// R6 - Store go starts programming, self-clears
// R7 - Store go ignored without prior enable
// R8 - Bit 1 fetch enable gates reads
// R9 - Fetch go starts read, self-clears
// R10 - Fetch go ignored without prior enable
// R11 - Software never sets both go bits
// R12 - Fetched byte held in data register
// R13 - Software loads, enables, then goes
// R14 - Software masks interrupts around store start
// R15 - Async timer completion synchronised first
// R16 - Store end: go clears, interrupt raised
// R17 - Control, address, data reset to zero
// R18 - Pointer high bytes reset to zero
// R19 - Done flag set, auto-cleared, enable-gated
// R20 - No sleep until access completes
// R21 - Read completes in fixed short cycles
package dea_pkg;

    // Array geometry
    localparam int unsigned ARRAY_DEPTH     = 64;
    localparam int unsigned ADDR_W          = 6;
    localparam int unsigned DATA_W          = 8;

    // Sector 0 register offsets on the special function register bus
    localparam logic [7:0]  OFS_ADDRESS     = 8'h20;
    localparam logic [7:0]  OFS_DATA        = 8'h21;
    localparam logic [7:0]  OFS_PTR1_LOW    = 8'h03;
    localparam logic [7:0]  OFS_PTR1_HIGH   = 8'h04;
    localparam logic [7:0]  OFS_PTR2_LOW    = 8'h05;
    localparam logic [7:0]  OFS_PTR2_HIGH   = 8'h06;
    localparam logic [7:0]  OFS_IND_PORT1   = 8'h01;
    localparam logic [7:0]  OFS_IND_PORT2   = 8'h02;

    // Pointer value that selects the control register in sector 1
    localparam logic [7:0]  CTRL_PTR_LOW    = 8'h40;
    localparam logic [7:0]  CTRL_PTR_HIGH   = 8'h01;

    // Control register field positions
    localparam int unsigned BIT_STORE_EN    = 3;
    localparam int unsigned BIT_STORE_GO    = 2;
    localparam int unsigned BIT_FETCH_EN    = 1;
    localparam int unsigned BIT_FETCH_GO    = 0;

    // Values after reset
    localparam logic [7:0]  RST_BYTE        = 8'h00;
    localparam logic [5:0]  RST_ADDR        = 6'h00;
    localparam logic        RST_BIT         = 1'b0;

    // Read cycle length in system clocks
    localparam logic [1:0]  FETCH_CYCLES    = 2'h2;

    // Sequencer states
    typedef enum logic [1:0] {
        DEA_IDLE,
        DEA_FETCH,
        DEA_STORE
    } dea_state_t;

endpackage : dea_pkg

// ==== logic/dea_sync.sv ====
`timescale 1ns/1ps
// Two-stage synchroniser for a level from outside the clock domain
module dea_sync (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic async_in,
    output logic      sync_out
);
    import dea_pkg::*;

    // Both stages in one state word
    typedef struct packed {
        logic s1;   // Metastability catcher, read only by s2
        logic s2;   // Safe level
    } dea_sync_st_t;

    dea_sync_st_t st_r;     // Registered state
    dea_sync_st_t st_nxt;   // Next state

    // Shift the level through both stages
    always_comb begin
        st_nxt.s1 = async_in;
        st_nxt.s2 = st_r.s1;
        if (!rstn) begin
            st_nxt.s1 = RST_BIT;
            st_nxt.s2 = RST_BIT;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        st_r <= st_nxt;
    end

    assign sync_out = st_r.s2;

endmodule : dea_sync

// ==== logic/dea_array.sv ====
`timescale 1ns/1ps
// Byte array: one write port, one registered read port
module dea_array (
    input  wire logic        clk,
    input  wire logic        wr_en,
    input  wire logic [5:0]  wr_addr,
    input  wire logic [7:0]  wr_data,
    input  wire logic [5:0]  rd_addr,
    output logic      [7:0]  rd_data
);
    import dea_pkg::*;

    // Contents and read latch; no reset since the array is non-volatile
    typedef struct packed {
        logic [ARRAY_DEPTH-1:0][DATA_W-1:0] mem;    // 64 bytes R1
        logic [DATA_W-1:0]                  rdata;  // Read latch
    } dea_array_st_t;

    dea_array_st_t st_r;    // Registered state
    dea_array_st_t st_nxt;  // Next state

    // Write one byte when enabled, read one byte every cycle
    always_comb begin
        st_nxt       = st_r;
        st_nxt.rdata = st_r.mem[rd_addr];
        if (wr_en) begin
            st_nxt.mem[wr_addr] = wr_data;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        st_r <= st_nxt;
    end

    assign rd_data = st_r.rdata;

endmodule : dea_array

// ==== logic/dea_ctrl.sv ====
`timescale 1ns/1ps
// Data array access controller behind the special function register bus
module dea_ctrl (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_wr,
    input  wire logic        sfr_rd,
    input  wire logic [7:0]  sfr_wdata,
    output logic      [7:0]  sfr_rdata,
    output logic             prog_timer_run,
    input  wire logic        prog_timer_done,
    input  wire logic        nvm_done_irq_enable,
    input  wire logic        irq_ack,
    output logic             nvm_done_flag,
    output logic             nvm_irq_req
);
    import dea_pkg::*;

    // Whole controller state
    typedef struct packed {
        dea_state_t  state;       // Sequencer
        logic [5:0]  address;     // Array address, six bits only
        logic [7:0]  data;        // Data register
        logic        store_en;    // Control bit 3
        logic        store_go;    // Control bit 2
        logic        fetch_en;    // Control bit 1
        logic        fetch_go;    // Control bit 0
        logic [7:0]  p1_low;      // Pointer 1 low byte
        logic [7:0]  p1_high;     // Pointer 1 high byte
        logic [7:0]  p2_low;      // Pointer 2 low byte
        logic [7:0]  p2_high;     // Pointer 2 high byte
        logic [1:0]  cnt;         // Read cycle counter
        logic [5:0]  prog_addr;   // Address latched at store start
        logic [7:0]  prog_data;   // Byte latched at store start
        logic        timer_run;   // Request to the programming timer
        logic        done_prev;   // Last synchronised timer done
        logic        flag;        // Store complete flag
        logic        irq;         // Gated interrupt request
        logic [7:0]  rdata;       // Bus read latch
        logic        arr_we;      // Array write strobe
    } dea_ctrl_st_t;

    dea_ctrl_st_t st_r;         // Registered state
    dea_ctrl_st_t st_nxt;       // Next state
    logic         done_sync;    // Timer done, synchronised
    logic         done_rise;    // Timer done edge
    logic [7:0]   arr_rdata;    // Array read data
    logic         hit1;         // Pointer 1 selects control
    logic         hit2;         // Pointer 2 selects control
    logic         ctrl_wr;      // Control register write
    logic         ctrl_rd;      // Control register read
    logic [7:0]   ctrl_val;     // Control register as read

    // Timer runs on its own oscillator, so its done level is synchronised
    dea_sync u_done_sync (
        .clk      (clk),
        .rstn     (rstn),
        .async_in (prog_timer_done),
        .sync_out (done_sync)
    );

    // Storage; reads always track the address register
    dea_array u_array (
        .clk     (clk),
        .wr_en   (st_r.arr_we),
        .wr_addr (st_r.prog_addr),
        .wr_data (st_r.prog_data),
        .rd_addr (st_r.address),
        .rd_data (arr_rdata)
    );

    // Control reachable only through a pointer aimed at sector 1, 40H
    always_comb begin
        hit1     = (st_r.p1_high == CTRL_PTR_HIGH) && (st_r.p1_low == CTRL_PTR_LOW); // R3
        hit2     = (st_r.p2_high == CTRL_PTR_HIGH) && (st_r.p2_low == CTRL_PTR_LOW); // R3
        ctrl_wr  = sfr_wr && (((sfr_addr == OFS_IND_PORT1) && hit1)
                            || ((sfr_addr == OFS_IND_PORT2) && hit2));
        ctrl_rd  = sfr_rd && (((sfr_addr == OFS_IND_PORT1) && hit1)
                            || ((sfr_addr == OFS_IND_PORT2) && hit2));
        ctrl_val = {4'h0, st_r.store_en, st_r.store_go, st_r.fetch_en, st_r.fetch_go}; // R5
        done_rise = done_sync && !st_r.done_prev; // R15
    end

    // Next-state logic
    always_comb begin
        st_nxt           = st_r;
        st_nxt.arr_we    = 1'b0;
        st_nxt.done_prev = done_sync;

        // Direct sector 0 writes; one byte per access R2
        if (sfr_wr) begin
            case (sfr_addr)
                OFS_ADDRESS:   st_nxt.address = sfr_wdata[5:0]; // R4
                OFS_DATA:      st_nxt.data    = sfr_wdata;
                OFS_PTR1_LOW:  st_nxt.p1_low  = sfr_wdata;
                OFS_PTR1_HIGH: st_nxt.p1_high = sfr_wdata;
                OFS_PTR2_LOW:  st_nxt.p2_low  = sfr_wdata;
                OFS_PTR2_HIGH: st_nxt.p2_high = sfr_wdata;
                default: begin
                    // Other addresses belong to other blocks
                end
            endcase
        end

        // Indirect control write; go bits judged against the old enables
        if (ctrl_wr) begin
            st_nxt.store_en = sfr_wdata[BIT_STORE_EN]; // R5
            st_nxt.fetch_en = sfr_wdata[BIT_FETCH_EN]; // R8
            if (st_r.state == DEA_IDLE) begin
                // Store wins if software breaks the one-go-bit contract R11
                if (sfr_wdata[BIT_STORE_GO] && st_r.store_en) begin // R7
                    st_nxt.store_go  = 1'b1; // R6
                    st_nxt.timer_run = 1'b1;
                    st_nxt.prog_addr = st_r.address;
                    st_nxt.prog_data = st_r.data;
                    st_nxt.state     = DEA_STORE;
                end else if (sfr_wdata[BIT_FETCH_GO] && st_r.fetch_en) begin // R10
                    st_nxt.fetch_go = 1'b1; // R9
                    st_nxt.cnt      = FETCH_CYCLES - 2'h1;
                    st_nxt.state    = DEA_FETCH;
                end
            end
        end

        // Service clears the flag; a completion below overrides it
        if (irq_ack) begin
            st_nxt.flag = 1'b0; // R19
        end

        // Sequencer
        case (st_r.state)
            DEA_IDLE: begin
                // Waiting for a go bit
            end
            DEA_FETCH: begin
                if (!st_r.fetch_en) begin
                    // Enable dropped mid-read: abandon, data untouched R8
                    st_nxt.fetch_go = 1'b0;
                    st_nxt.state    = DEA_IDLE;
                end else if (st_r.cnt == 2'h0) begin
                    st_nxt.data     = arr_rdata; // R12
                    st_nxt.fetch_go = 1'b0; // R21
                    st_nxt.state    = DEA_IDLE;
                end else begin
                    st_nxt.cnt = st_r.cnt - 2'h1;
                end
            end
            DEA_STORE: begin
                // Programming continues even if store enable is cleared late
                if (done_rise) begin // R15
                    st_nxt.store_go  = 1'b0; // R16
                    st_nxt.timer_run = 1'b0;
                    st_nxt.arr_we    = 1'b1;
                    st_nxt.flag      = 1'b1; // R19
                    st_nxt.state     = DEA_IDLE;
                end
            end
            default: begin
                st_nxt.state = DEA_IDLE;
            end
        endcase

        // Request only reaches the core while its enable is set
        st_nxt.irq = st_nxt.flag && nvm_done_irq_enable; // R19

        // Registered read data; unmapped addresses read zero
        if (sfr_rd) begin
            case (sfr_addr)
                OFS_ADDRESS:   st_nxt.rdata = {2'h0, st_r.address}; // R4
                OFS_DATA:      st_nxt.rdata = st_r.data;
                OFS_PTR1_LOW:  st_nxt.rdata = st_r.p1_low;
                OFS_PTR1_HIGH: st_nxt.rdata = st_r.p1_high;
                OFS_PTR2_LOW:  st_nxt.rdata = st_r.p2_low;
                OFS_PTR2_HIGH: st_nxt.rdata = st_r.p2_high;
                default:       st_nxt.rdata = ctrl_rd ? ctrl_val : RST_BYTE; // R3
            endcase
        end

        // Synchronous reset; the array itself keeps its contents
        if (!rstn) begin
            st_nxt.state     = DEA_IDLE;
            st_nxt.address   = RST_ADDR; // R17
            st_nxt.data      = RST_BYTE; // R17
            st_nxt.store_en  = RST_BIT; // R17
            st_nxt.store_go  = RST_BIT;
            st_nxt.fetch_en  = RST_BIT;
            st_nxt.fetch_go  = RST_BIT;
            st_nxt.p1_low    = RST_BYTE;
            st_nxt.p1_high   = RST_BYTE; // R18
            st_nxt.p2_low    = RST_BYTE;
            st_nxt.p2_high   = RST_BYTE; // R18
            st_nxt.cnt       = 2'h0;
            st_nxt.prog_addr = RST_ADDR;
            st_nxt.prog_data = RST_BYTE;
            st_nxt.timer_run = RST_BIT;
            st_nxt.done_prev = RST_BIT;
            st_nxt.flag      = RST_BIT;
            st_nxt.irq       = RST_BIT;
            st_nxt.rdata     = RST_BYTE;
            st_nxt.arr_we    = RST_BIT;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        st_r <= st_nxt;
    end

    // Outputs straight from flip-flops
    assign sfr_rdata      = st_r.rdata;
    assign prog_timer_run = st_r.timer_run;
    assign nvm_done_flag  = st_r.flag;
    assign nvm_irq_req    = st_r.irq;

    // Checks
    default clocking dea_cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    a_addr_upper_zero: assert property ( // R4
        (sfr_rd && sfr_addr == OFS_ADDRESS) |=> (sfr_rdata[7:6] == 2'h0))
        else $error("address register upper bits not zero");

    a_ctrl_upper_zero: assert property ( // R5
        ctrl_rd |=> (sfr_rdata[7:4] == 4'h0))
        else $error("control register upper bits not zero");

    a_store_needs_en: assert property ( // R7
        (ctrl_wr && sfr_wdata[BIT_STORE_GO] && !st_r.store_en && !st_r.store_go)
        |=> !st_r.store_go)
        else $error("store started without prior enable");

    a_fetch_needs_en: assert property ( // R10
        (ctrl_wr && sfr_wdata[BIT_FETCH_GO] && !st_r.fetch_en && !st_r.fetch_go)
        |=> !st_r.fetch_go)
        else $error("fetch started without prior enable");

    a_fetch_bounded: assert property ( // R21
        $rose(st_r.fetch_go) |-> ##[1:2] !st_r.fetch_go)
        else $error("read cycle too long");

    a_fetch_data_load: assert property ( // R12
        ($fell(st_r.fetch_go) && $past(st_r.fetch_en)) |-> (st_r.data == $past(arr_rdata)))
        else $error("data register not loaded at read end");

    a_data_held: assert property ( // R12
        (st_r.state == DEA_IDLE && !(sfr_wr && sfr_addr == OFS_DATA)) |=> $stable(st_r.data))
        else $error("data register changed while idle");

    a_store_done: assert property ( // R16
        (st_r.state == DEA_STORE && done_rise)
        |=> (!st_r.store_go && nvm_done_flag && st_r.arr_we && !prog_timer_run))
        else $error("store end not signalled");

    a_timer_has_go: assert property ( // R6
        prog_timer_run |-> st_r.store_go)
        else $error("timer running without store go");

    a_irq_gated: assert property ( // R19
        nvm_irq_req |-> $past(nvm_done_irq_enable))
        else $error("interrupt raised while disabled");

    a_ptr_reset: assert property (@(posedge clk) disable iff (1'b0) // R18
        !rstn |=> (st_r.p1_high == RST_BYTE && st_r.p2_high == RST_BYTE))
        else $error("pointer high bytes not cleared by reset");

    // Only one cycle may run at a time, whatever software writes
    a_go_exclusive: assert property ( // R11
        !(st_r.store_go && st_r.fetch_go))
        else $error("store and fetch running together");

    // The byte programmed is the one loaded before the go write
    a_store_latch: assert property ( // R6
        $rose(st_r.store_go) |-> (st_r.prog_addr == $past(st_r.address)
                                  && st_r.prog_data == $past(st_r.data)))
        else $error("store did not latch address and data");

    // Programming only ends on a synchronised timer edge
    a_store_waits: assert property ( // R15
        (st_r.state == DEA_STORE && !done_rise) |=> st_r.store_go)
        else $error("store ended without timer done");

    // Array is written only at the end of programming
    a_write_at_end: assert property ( // R16
        st_r.arr_we |-> $past(st_r.state == DEA_STORE && done_rise))
        else $error("array written outside store end");

    // Service clears the flag unless a completion lands in the same cycle
    a_flag_cleared: assert property ( // R19
        (irq_ack && !(st_r.state == DEA_STORE && done_rise)) |=> !nvm_done_flag)
        else $error("done flag not cleared by service");

    // Dropping fetch enable abandons the read and keeps the data register
    a_fetch_abort: assert property ( // R8
        (st_r.state == DEA_FETCH && !st_r.fetch_en && !(sfr_wr && sfr_addr == OFS_DATA))
        |=> (!st_r.fetch_go && $stable(st_r.data)))
        else $error("aborted read changed state");

    // Writes that miss the control register leave the enables alone
    a_ctrl_gated: assert property ( // R3
        (sfr_wr && !ctrl_wr) |=> ($stable(st_r.store_en) && $stable(st_r.fetch_en)))
        else $error("control changed by a missed write");

    c_fetch_done:   cover property ($fell(st_r.fetch_go) && st_r.fetch_en);
    c_store_done:   cover property (st_r.state == DEA_STORE && done_rise);
    c_store_refuse: cover property (ctrl_wr && sfr_wdata[BIT_STORE_GO] && !st_r.store_en);
    c_ctrl_via_p2:  cover property (ctrl_wr && sfr_addr == OFS_IND_PORT2);

endmodule : dea_ctrl

// ==== verification/dea_timer_model.sv ====
`timescale 1ns/1ps
// Programming timer on the far side: runs on its own time, unrelated to clk
module dea_timer_model #(
    parameter int unsigned PROG_NS = 137  // Programming time, arbitrary short value
) (
    input  wire logic prog_timer_run,
    output logic      prog_timer_done
);
    // Done rises after the programming time and falls once the request goes away,
    // so every store sees a fresh rising edge
    initial begin
        prog_timer_done = 1'b0;
        forever begin
            @(posedge prog_timer_run);
            #(PROG_NS);
            prog_timer_done = 1'b1;
            wait (prog_timer_run == 1'b0);
            #7;
            prog_timer_done = 1'b0;
        end
    end
endmodule : dea_timer_model

// ==== verification/dea_ctrl_tb.sv ====
`timescale 1ns/1ps
// Self-checking bench for the data array access controller
module dea_ctrl_tb;
    import dea_pkg::*;
    logic       clk, rstn, sfr_wr, sfr_rd, irq_en, irq_ack;  // Bench-driven inputs
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;              // Register bus
    logic       t_run, t_done, done_flag, irq_req;           // Timer and interrupt
    int         failures, num_checks;                        // Verdict counters
    logic [7:0] rv;                                          // Last value read

    dea_ctrl i_dea_ctrl (.clk(clk), .rstn(rstn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .prog_timer_run(t_run), .prog_timer_done(t_done), .nvm_done_irq_enable(irq_en),
        .irq_ack(irq_ack), .nvm_done_flag(done_flag), .nvm_irq_req(irq_req));
    dea_timer_model i_dea_timer_model (.prog_timer_run(t_run), .prog_timer_done(t_done));

    // 100 MHz system clock
    initial clk = 1'b0;
    always #5 clk = ~clk;

    // Byte compare
    task automatic chk8(string what, logic [7:0] exp, logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk8

    // Single-bit compare
    task automatic chk1(string what, logic exp, logic got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %b seen %b", what, exp, got);
        end
    endtask : chk1

    // One write; idle edge first so the strobe is never assigned twice at once
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge clk);
        sfr_addr = a; sfr_wdata = d; sfr_wr = 1'b1;
        @(negedge clk);
        sfr_wr = 1'b0;
    endtask : wr

    // One read; data is registered and settled by the next falling edge
    task automatic rd(logic [7:0] a);
        @(negedge clk);
        sfr_addr = a; sfr_rd = 1'b1;
        @(negedge clk);
        sfr_rd = 1'b0;
        rv = sfr_rdata;
    endtask : rd

    // Point a pointer pair at the control register
    task automatic aim(logic [7:0] lo, logic [7:0] hi);
        wr(lo, CTRL_PTR_LOW);
        wr(hi, CTRL_PTR_HIGH);
    endtask : aim

    // Poll the control register until a go bit clears, bounded
    task automatic wait_go(int b);
        for (int i = 0; i < 60; i++) begin
            rd(OFS_IND_PORT1);
            if (rv[b] === 1'b0) return;
        end
        failures++;
        $display("unexpected go bit %0d: expected 0 seen 1", b);
        final_report();
    endtask : wait_go

    // Reset values and sector gating
    task automatic t_reset;
        rd(OFS_ADDRESS);   chk8("address reset", 8'h00, rv);
        rd(OFS_DATA);      chk8("data reset", 8'h00, rv);
        rd(OFS_PTR1_HIGH); chk8("ptr1 high reset", 8'h00, rv);
        rd(OFS_PTR2_HIGH); chk8("ptr2 high reset", 8'h00, rv);
        wr(OFS_PTR1_LOW, CTRL_PTR_LOW);
        wr(OFS_IND_PORT1, 8'h0A);
        rd(OFS_IND_PORT1); chk8("ctrl in sector 0", 8'h00, rv);
        aim(OFS_PTR1_LOW, OFS_PTR1_HIGH);
        rd(OFS_IND_PORT1); chk8("ctrl reset", 8'h00, rv);
        $display("test reset done");
    endtask : t_reset

    // Unimplemented bits, unmapped place, go without enable
    task automatic t_fields;
        wr(OFS_ADDRESS, 8'hFF);
        rd(OFS_ADDRESS);   chk8("address width", 8'h3F, rv);
        rd(8'h7E);         chk8("unmapped read", 8'h00, rv);
        wr(OFS_IND_PORT1, 8'hF0);
        rd(OFS_IND_PORT1); chk8("ctrl top bits", 8'h00, rv);
        wr(OFS_IND_PORT1, 8'h04);
        rd(OFS_IND_PORT1); chk8("store go alone", 8'h00, rv);
        wr(OFS_IND_PORT1, 8'h01);
        rd(OFS_IND_PORT1); chk8("fetch go alone", 8'h00, rv);
        chk1("timer idle", 1'b0, t_run);
        $display("test fields done");
    endtask : t_fields

    // Store a byte at the top address, then check completion and interrupt
    task automatic t_store;
        irq_en = 1'b0;
        wr(OFS_ADDRESS, 8'h3F);
        wr(OFS_DATA, 8'hA5);
        wr(OFS_IND_PORT1, 8'h08);
        wr(OFS_IND_PORT1, 8'h0C);
        @(negedge clk);
        irq_en = 1'b1;
        chk1("timer run", 1'b1, t_run);
        chk1("flag early", 1'b0, done_flag);
        wait_go(BIT_STORE_GO);
        chk1("timer run end", 1'b0, t_run);
        chk1("done flag", 1'b1, done_flag);
        chk1("irq request", 1'b1, irq_req);
        irq_en = 1'b0;
        repeat (2) @(negedge clk);
        chk1("irq masked", 1'b0, irq_req);
        chk1("flag kept", 1'b1, done_flag);
        irq_ack = 1'b1;
        @(negedge clk);
        irq_ack = 1'b0;
        @(negedge clk);
        chk1("flag cleared", 1'b0, done_flag);
        wr(OFS_IND_PORT1, 8'h00);
        $display("test store done");
    endtask : t_store

    // Fetch the stored byte back through the second pointer pair
    task automatic t_fetch;
        wr(OFS_DATA, 8'h00);
        aim(OFS_PTR2_LOW, OFS_PTR2_HIGH);
        wr(OFS_IND_PORT2, 8'h02);
        wr(OFS_IND_PORT2, 8'h03);
        wait_go(BIT_FETCH_GO);
        rd(OFS_DATA);      chk8("fetched byte", 8'hA5, rv);
        repeat (4) @(negedge clk);
        rd(OFS_DATA);      chk8("byte held", 8'hA5, rv);
        wr(OFS_IND_PORT2, 8'h00);
        wr(OFS_IND_PORT2, 8'h01);
        rd(OFS_IND_PORT2); chk8("fetch disabled", 8'h00, rv);
        chk1("no store", 1'b0, done_flag);
        $display("test fetch done");
    endtask : t_fetch

    // Verdict and end of run
    task automatic final_report;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report

    // Main sequence
    initial begin
        failures = 0; num_checks = 0;
        rstn = 1'b0; sfr_wr = 1'b0; sfr_rd = 1'b0; irq_en = 1'b1; irq_ack = 1'b0;
        sfr_addr = 8'h00; sfr_wdata = 8'h00;
        repeat (5) @(negedge clk);
        rstn = 1'b1;
        t_reset();
        t_fields();
        t_store();
        t_fetch();
        final_report();
    end
endmodule : dea_ctrl_tb
